/* logic/dram_timing_consts.svh */
`ifndef DRAM_TIMING_CONSTS_SVH
`define DRAM_TIMING_CONSTS_SVH

// register byte offsets
`define T1_OFS 16'h1214
`define T2_OFS 16'h1218
`define T3_OFS 16'h121C
`define M0_OFS 16'h1230
`define MC_OFS 16'h1240

// reset values
`define T1_RST 32'h11E08463
`define T2_RST 32'h2200105F
`define T3_RST 32'h01056102
`define M0_RST 32'h4F000008
`define MC_RST 32'h00000000

// writable bits; all others read back their reset value, except MC bit 1, which reads the live reserved-code status
`define T1_WMASK 32'h33E49CE7
`define T2_WMASK 32'hFFFFFFFF
`define T3_WMASK 32'h3F9FE787
`define M0_WMASK 32'h0F010708
`define MC_WMASK 32'h00000001

// field positions (low bit of each field)
`define RCD_LO 5
`define RP_LO 0
`define CL_LO 23
`define RFC_LO 13
`define WL_LO 0
`define DDR3_BIT 0

// largest legal codes
`define RCD_MAX 3'h6
`define RP_MAX 3'h5
`define CL_MAX_DDR2 3'h4
`define CL_MAX_DDR3 3'h5
`define WL_MAX 3'h5

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* logic/dram_timing_pkg.sv */
package dram_timing_pkg;

  // command kinds offered to the spacing check
  typedef enum logic [1:0] {
    CMD_ACT,
    CMD_READ,
    CMD_WRITE,
    CMD_PRE
  } cmd_kind_t;

  // register selected by an address
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_T1,
    SEL_T2,
    SEL_T3,
    SEL_M0,
    SEL_MC
  } reg_sel_t;

  // decoded timing handed to the command side, in dram clocks
  typedef struct packed {
    logic [3:0] act_to_column_delay;
    logic [3:0] precharge_to_act_delay;
    logic [3:0] cas_latency_field;
    logic [3:0] write_latency_field;
    logic [7:0] refresh_cycle_time;
    logic       ddr3;
    logic       reserved_code;
  } timing_cfg_t;

endpackage

/* logic/spacing_counter.sv */
`timescale 1ns/100ps
// counts down from the programmed span after a command; ok once the span has passed
module spacing_counter (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // control
  input  wire logic       start,
  input  wire logic [3:0] span,
  output logic            ok
);
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;

  // a fresh command restarts the wait even if one is still running
  always_comb begin
    if (start) begin
      cnt_d = span;
    end else if (cnt_q != 4'h0) begin
      cnt_d = cnt_q - 4'h1;
    end else begin
      cnt_d = cnt_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // count 1 means span cycles have passed since the start edge
  assign ok = (cnt_q <= 4'h1);

endmodule // spacing_counter

/* logic/dram_channel_timing_params.sv */
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/100ps
`include "dram_timing_consts.svh"
module dram_channel_timing_params (
  // clock and reset
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  // axi4-lite write
  input  wire logic                       awvalid,
  output logic                            awready,
  input  wire logic [15:0]                awaddr,
  input  wire logic                       wvalid,
  output logic                            wready,
  input  wire logic [31:0]                wdata,
  input  wire logic [3:0]                 wstrb,
  output logic                            bvalid,
  input  wire logic                       bready,
  output logic [1:0]                      bresp,
  // axi4-lite read
  input  wire logic                       arvalid,
  output logic                            arready,
  input  wire logic [15:0]                araddr,
  output logic                            rvalid,
  input  wire logic                       rready,
  output logic [31:0]                     rdata,
  output logic [1:0]                      rresp,
  // command spacing
  input  wire logic                       cmd_valid,
  input  wire dram_timing_pkg::cmd_kind_t cmd_kind,
  output logic                            cmd_ready,
  // decoded timing
  output dram_timing_pkg::timing_cfg_t    timing_cfg
);

  logic [31:0] t1_q, t1_d, t2_q, t2_d, t3_q, t3_d, m0_q, m0_d, mc_q, mc_d;
  logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic        wr_go, rd_go;
  dram_timing_pkg::reg_sel_t    wsel, rsel;
  dram_timing_pkg::timing_cfg_t cfg_q, cfg_d;
  logic        fire, act_ok, col_ok, is_col;

  // address decode; only word-aligned addresses map
  function automatic dram_timing_pkg::reg_sel_t reg_sel(input logic [15:0] a);
    if (a[1:0] != 2'h0) return dram_timing_pkg::SEL_NONE;
    case (a)
      `T1_OFS: return dram_timing_pkg::SEL_T1;
      `T2_OFS: return dram_timing_pkg::SEL_T2;
      `T3_OFS: return dram_timing_pkg::SEL_T3;
      `M0_OFS: return dram_timing_pkg::SEL_M0;
      `MC_OFS: return dram_timing_pkg::SEL_MC;
      default: return dram_timing_pkg::SEL_NONE;
    endcase
  endfunction

  // byte-enabled write limited to the writable bits
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb, input logic [31:0] wmask);
    logic [31:0] be;
    be = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old & ~(be & wmask)) | (wd & be & wmask);
  endfunction

  // code plus two clocks; reserved codes clamp to the longest legal spacing
  function automatic logic [3:0] delay_clks(input logic [2:0] code, input logic [2:0] maxc);
    logic [2:0] c;
    c = (code > maxc) ? maxc : code;
    return {1'b0, c} + 4'h2;
  endfunction

  // decode of the T1, T3 and MC registers into clock counts
  function automatic dram_timing_pkg::timing_cfg_t decode(input logic [31:0] t1,
                                                          input logic [31:0] t3,
                                                          input logic [31:0] mc);
    dram_timing_pkg::timing_cfg_t r;
    logic [2:0] cl, clmax;
    r = '0;
    r.ddr3 = mc[`DDR3_BIT];
    cl = t3[`CL_LO +: 3];
    clmax = r.ddr3 ? `CL_MAX_DDR3 : `CL_MAX_DDR2;
    r.act_to_column_delay = delay_clks(t1[`RCD_LO +: 3], `RCD_MAX);
    r.precharge_to_act_delay = delay_clks(t1[`RP_LO +: 3], `RP_MAX);
    // reserved cas code falls back to 7, the longest ddr2 latency
    r.cas_latency_field = {1'b0, (cl > clmax) ? 3'h4 : cl} + 4'h3;
    r.write_latency_field = delay_clks(t3[`WL_LO +: 3], `WL_MAX);
    r.refresh_cycle_time = t3[`RFC_LO +: 8];
    r.reserved_code = (t1[`RCD_LO +: 3] > `RCD_MAX) || (t1[`RP_LO +: 3] > `RP_MAX)
                      || (cl > clmax) || (t3[`WL_LO +: 3] > `WL_MAX);
    return r;
  endfunction

  // write channel: both address and data must be present, one response at a time
  assign wr_go   = awvalid && wvalid && !bvalid_q;
  assign awready = wr_go;
  assign wready  = wr_go;
  assign wsel    = reg_sel(awaddr);
  // read channel: one outstanding read
  assign rd_go   = arvalid && !rvalid_q;
  assign arready = !rvalid_q;
  assign rsel    = reg_sel(araddr);

  // register file next state
  always_comb begin
    t1_d = t1_q;
    t2_d = t2_q;
    t3_d = t3_q;
    m0_d = m0_q;
    mc_d = mc_q;
    bvalid_d = bvalid_q && !bready;
    bresp_d  = bresp_q;
    if (wr_go) begin
      bvalid_d = 1'b1;
      bresp_d  = `RESP_OKAY;
      case (wsel)
        dram_timing_pkg::SEL_T1: t1_d = merge(t1_q, wdata, wstrb, `T1_WMASK);
        dram_timing_pkg::SEL_T2: t2_d = merge(t2_q, wdata, wstrb, `T2_WMASK);
        dram_timing_pkg::SEL_T3: t3_d = merge(t3_q, wdata, wstrb, `T3_WMASK);
        dram_timing_pkg::SEL_M0: m0_d = merge(m0_q, wdata, wstrb, `M0_WMASK);
        dram_timing_pkg::SEL_MC: mc_d = merge(mc_q, wdata, wstrb, `MC_WMASK);
        default: bresp_d = `RESP_SLVERR;
      endcase
    end
  end

  // read data next state; status bit 1 of the mode word is live
  always_comb begin
    rvalid_d = rvalid_q && !rready;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (rd_go) begin
      rvalid_d = 1'b1;
      rresp_d  = `RESP_OKAY;
      case (rsel)
        dram_timing_pkg::SEL_T1: rdata_d = t1_q;
        dram_timing_pkg::SEL_T2: rdata_d = t2_q;
        dram_timing_pkg::SEL_T3: rdata_d = t3_q;
        dram_timing_pkg::SEL_M0: rdata_d = m0_q;
        dram_timing_pkg::SEL_MC: rdata_d = {30'h0, cfg_q.reserved_code, mc_q[0]};
        default: begin
          rdata_d = 32'h0;
          rresp_d = `RESP_SLVERR;
        end
      endcase
    end
  end

  // decoded copy lags a register write by one clock; cheaper than a wide comb path
  assign cfg_d = decode(t1_q, t3_q, mc_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      t1_q     <= `T1_RST;
      t2_q     <= `T2_RST;
      t3_q     <= `T3_RST;
      m0_q     <= `M0_RST;
      mc_q     <= `MC_RST;
      bvalid_q <= 1'b0;
      bresp_q  <= `RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0;
      rresp_q  <= `RESP_OKAY;
      cfg_q    <= decode(`T1_RST, `T3_RST, `MC_RST);
    end else begin
      t1_q     <= t1_d;
      t2_q     <= t2_d;
      t3_q     <= t3_d;
      m0_q     <= m0_d;
      mc_q     <= mc_d;
      bvalid_q <= bvalid_d;
      bresp_q  <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q  <= rdata_d;
      rresp_q  <= rresp_d;
      cfg_q    <= cfg_d;
    end
  end

  assign bvalid     = bvalid_q;
  assign bresp      = bresp_q;
  assign rvalid     = rvalid_q;
  assign rdata      = rdata_q;
  assign rresp      = rresp_q;
  assign timing_cfg = cfg_q;

  // spacing is tracked per channel, not per bank: conservative but never early
  assign is_col = (cmd_kind == dram_timing_pkg::CMD_READ)
                  || (cmd_kind == dram_timing_pkg::CMD_WRITE);
  assign fire   = cmd_valid && cmd_ready;

  spacing_counter u_act_col (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (fire && cmd_kind == dram_timing_pkg::CMD_ACT),
    .span    (cfg_q.act_to_column_delay),
    .ok      (col_ok)
  );

  spacing_counter u_pre_act (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (fire && cmd_kind == dram_timing_pkg::CMD_PRE),
    .span    (cfg_q.precharge_to_act_delay),
    .ok      (act_ok)
  );

  // hold a dependent command until its spacing has passed
  always_comb begin
    case (cmd_kind)
      dram_timing_pkg::CMD_ACT: cmd_ready = act_ok;
      dram_timing_pkg::CMD_READ,
      dram_timing_pkg::CMD_WRITE: cmd_ready = col_ok;
      default: cmd_ready = 1'b1;
    endcase
  end

  // checking: cycles since the last activate and precharge, saturating
  logic [7:0] since_act_q, since_pre_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      since_act_q <= 8'hFF;
      since_pre_q <= 8'hFF;
    end else begin
      since_act_q <= (fire && cmd_kind == dram_timing_pkg::CMD_ACT) ? 8'h01
                     : (since_act_q == 8'hFF ? 8'hFF : since_act_q + 8'h01);
      since_pre_q <= (fire && cmd_kind == dram_timing_pkg::CMD_PRE) ? 8'h01
                     : (since_pre_q == 8'hFF ? 8'hFF : since_pre_q + 8'h01);
    end
  end

  rcd_decode_a: assert property (@(posedge aclk) disable iff (!aresetn)
    1 |=> cfg_q.act_to_column_delay == {1'b0, ($past(t1_q[`RCD_LO +: 3]) == 3'h7 ? 3'h6
          : $past(t1_q[`RCD_LO +: 3]))} + 4'h2)
    else $error("activate-to-column decode wrong");
  rp_decode_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg_q.precharge_to_act_delay >= 4'h2 && cfg_q.precharge_to_act_delay <= 4'h7)
    else $error("precharge-to-activate out of range");
  cl_ddr3_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (t3_q[`CL_LO +: 3] == 3'h5 && mc_q[0]) |=> cfg_q.cas_latency_field == 4'h8)
    else $error("ddr3 cas code 5 not decoded as 8");
  wl_decode_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (t3_q[`WL_LO +: 3] <= 3'h5) |=> cfg_q.write_latency_field == {1'b0,
      $past(t3_q[`WL_LO +: 3])} + 4'h2)
    else $error("write latency decode wrong");
  two_reset_a: assert property (@(posedge aclk)
    !aresetn |=> t2_q == `T2_RST)
    else $error("second timing register reset value wrong");
  col_spacing_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (fire && is_col) |-> since_act_q >= {4'h0, cfg_q.act_to_column_delay})
    else $error("column command too soon after activate");
  act_spacing_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (fire && cmd_kind == dram_timing_pkg::CMD_ACT)
      |-> since_pre_q >= {4'h0, cfg_q.precharge_to_act_delay})
    else $error("activate too soon after precharge");

  act_then_col_c: cover property (@(posedge aclk) disable iff (!aresetn)
    (fire && cmd_kind == dram_timing_pkg::CMD_ACT) ##[1:20] (fire && is_col));
  pre_then_act_c: cover property (@(posedge aclk) disable iff (!aresetn)
    (fire && cmd_kind == dram_timing_pkg::CMD_PRE)
      ##[1:20] (fire && cmd_kind == dram_timing_pkg::CMD_ACT));
  reg_write_c: cover property (@(posedge aclk) disable iff (!aresetn)
    wr_go && wsel == dram_timing_pkg::SEL_T3);

endmodule // dram_channel_timing_params

/* bench/dimm_model.sv */
`timescale 1ns/100ps
// far-side observer: counts commands that land inside their programmed spacing
module dimm_model (
  // clock and reset
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  // issued commands
  input  wire logic                         issued,
  input  wire dram_timing_pkg::cmd_kind_t   kind,
  input  wire dram_timing_pkg::timing_cfg_t cfg,
  // result
  output int                                faults
);
  int   since_act;
  int   since_pre;
  logic col_early;
  logic act_early;

  // a command that lands inside its spacing is a fault
  always_comb begin
    col_early = issued && (kind == dram_timing_pkg::CMD_READ || kind == dram_timing_pkg::CMD_WRITE)
                && since_act < 32'(cfg.act_to_column_delay);
    act_early = issued && kind == dram_timing_pkg::CMD_ACT
                && since_pre < 32'(cfg.precharge_to_act_delay);
  end

  // ages saturate so an idle channel never wraps into a false fault
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      since_act <= 99;
      since_pre <= 99;
      faults    <= 0;
    end else begin
      if (issued && kind == dram_timing_pkg::CMD_ACT) begin
        since_act <= 1;
      end else if (since_act < 99) begin
        since_act <= since_act + 1;
      end
      if (issued && kind == dram_timing_pkg::CMD_PRE) begin
        since_pre <= 1;
      end else if (since_pre < 99) begin
        since_pre <= since_pre + 1;
      end
      faults <= faults + 32'(col_early) + 32'(act_early);
    end
  end
endmodule // dimm_model

/* bench/test_dram_channel_timing_params.sv */
`timescale 1ns/100ps
`include "dram_timing_consts.svh"
module test_dram_channel_timing_params;
  logic                         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic                         awready, wready, bvalid, arready, rvalid, cmd_valid, cmd_ready;
  logic [15:0]                  awaddr, araddr;
  logic [31:0]                  wdata, rdata;
  logic [3:0]                   wstrb;
  logic [1:0]                   bresp, rresp;
  dram_timing_pkg::cmd_kind_t   cmd_kind;
  dram_timing_pkg::timing_cfg_t cfg;
  int                           bad_count, samples_checked, faults;

  dram_channel_timing_params dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_ready(cmd_ready),
    .timing_cfg(cfg));

  dimm_model partner (.aclk(aclk), .aresetn(aresetn), .issued(cmd_valid & cmd_ready),
    .kind(cmd_kind), .cfg(cfg), .faults(faults));

  // 40 MHz clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task give_verdict;
    $display("checked %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // a handshake that never comes ends the run
  task hang(input string what);
    bad_count++;
    $display("Error %s expected high seen low", what);
    give_verdict();
  endtask

  // one write; each channel is let go at its own ready, bready stays up until the answer
  task wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
    int   n;
    logic aw_left;
    logic w_left;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hF;
    bready  <= 1'b1;
    aw_left = 1'b1;
    w_left  = 1'b1;
    n = 0;
    while ((aw_left || w_left) && n < 20) begin
      @(posedge aclk);
      n++;
      if (aw_left && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw_left = 1'b0;
      end
      if (w_left && wready === 1'b1) begin
        wvalid <= 1'b0;
        w_left = 1'b0;
      end
    end
    if (aw_left || w_left) hang("awready and wready");
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (bvalid !== 1'b1 && n < 20);
    if (bvalid !== 1'b1) hang("bvalid");
    bready <= 1'b0;
    chk("bresp", 32'(er), 32'(bresp));
    // one idle edge so a following call never re-raises bready in this time step
    @(posedge aclk);
  endtask

  // one read; rready stays up until the answer, whose data is taken at that edge
  task rd(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (arready !== 1'b1 && n < 20);
    if (arready !== 1'b1) hang("arready");
    arvalid <= 1'b0;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (rvalid !== 1'b1 && n < 20);
    if (rvalid !== 1'b1) hang("rvalid");
    rready <= 1'b0;
    chk("rdata", ed, rdata);
    chk("rresp", 32'(er), 32'(rresp));
    @(posedge aclk);
  endtask

  // issue a, then count edges until b is let through
  task space(input dram_timing_pkg::cmd_kind_t a, b, input int n);
    int k;
    cmd_valid <= 1'b1;
    cmd_kind  <= a;
    @(posedge aclk);
    chk("first ready", 32'h1, 32'(cmd_ready));
    cmd_kind <= b;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
    end while (cmd_ready !== 1'b1 && k < 20);
    cmd_valid <= 1'b0;
    chk("spacing", n, k);
  endtask

  task test_reset;
    rd(`T1_OFS, 32'h11E08463, `RESP_OKAY);
    rd(`T2_OFS, 32'h2200105F, `RESP_OKAY);
    rd(`T3_OFS, 32'h01056102, `RESP_OKAY);
    rd(`M0_OFS, 32'h4F000008, `RESP_OKAY);
    rd(`MC_OFS, 32'h00000000, `RESP_OKAY);
    rd(16'h1220, 32'h00000000, `RESP_SLVERR);
    chk("rcd", 32'h5, 32'(cfg.act_to_column_delay));
    chk("rp", 32'h5, 32'(cfg.precharge_to_act_delay));
    chk("cl", 32'h5, 32'(cfg.cas_latency_field));
    chk("wl", 32'h4, 32'(cfg.write_latency_field));
    chk("rfc", 32'h2B, 32'(cfg.refresh_cycle_time));
    chk("ddr3", 32'h0, 32'(cfg.ddr3));
    chk("reserved", 32'h0, 32'(cfg.reserved_code));
  endtask

  task test_mask;
    wr(`T1_OFS, 32'hFFFFFFFF, `RESP_OKAY);
    rd(`T1_OFS, 32'h33E49CE7 | 32'h11E08463, `RESP_OKAY);
    wr(16'h1222, 32'hFFFFFFFF, `RESP_SLVERR);
    wr(`M0_OFS, 32'hFFFFFFFF, `RESP_OKAY);
    rd(`M0_OFS, 32'h4F010708, `RESP_OKAY);
    wr(`T2_OFS, 32'h2200105F, `RESP_OKAY);
    rd(`T2_OFS, 32'h2200105F, `RESP_OKAY);
  endtask

  // every activate-to-column code, 111 clamps to the longest
  task test_rcd;
    for (int c = 0; c < 8; c++) begin
      wr(`T1_OFS, (32'h11E08463 & ~32'hE0) | (c << 5), `RESP_OKAY);
      space(dram_timing_pkg::CMD_ACT, c[0] ? dram_timing_pkg::CMD_READ :
            dram_timing_pkg::CMD_WRITE, c < 7 ? c + 2 : 8);
    end
  endtask

  task test_rp;
    for (int c = 0; c < 6; c++) begin
      wr(`T1_OFS, (32'h11E08463 & ~32'h7) | c, `RESP_OKAY);
      space(dram_timing_pkg::CMD_PRE, dram_timing_pkg::CMD_ACT, c + 2);
    end
  endtask

  // write latency kept one below cas latency on ddr2, except cas code 5 (reserved), where both decode to 7
  task test_cas;
    for (int c = 0; c < 6; c++) begin
      wr(`T3_OFS, (32'h01056102 & ~32'h03800007) | (c << 23) | c, `RESP_OKAY);
      @(posedge aclk);
      chk("cl", c < 5 ? c + 3 : 7, 32'(cfg.cas_latency_field));
      chk("wl", c + 2, 32'(cfg.write_latency_field));
      chk("reserved", c == 5, 32'(cfg.reserved_code));
    end
    rd(`MC_OFS, 32'h00000002, `RESP_OKAY);
    wr(`MC_OFS, 32'h1, `RESP_OKAY);
    @(posedge aclk);
    chk("ddr3", 32'h1, 32'(cfg.ddr3));
    chk("ddr3 cl", 32'h8, 32'(cfg.cas_latency_field));
    chk("ddr3 reserved", 32'h0, 32'(cfg.reserved_code));
    rd(`MC_OFS, 32'h00000001, `RESP_OKAY);
    wr(`MC_OFS, 32'h0, `RESP_OKAY);
  endtask

  // inputs settled at time zero, reset for 16 cycles
  initial begin
    aresetn         = 1'b0;
    awvalid         = 1'b0;
    wvalid          = 1'b0;
    bready          = 1'b0;
    arvalid         = 1'b0;
    rready          = 1'b0;
    cmd_valid       = 1'b0;
    cmd_kind        = dram_timing_pkg::CMD_PRE;
    awaddr          = 16'h0;
    araddr          = 16'h0;
    wdata           = 32'h0;
    wstrb           = 4'h0;
    bad_count       = 0;
    samples_checked = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    test_reset();
    test_mask();
    test_rcd();
    test_rp();
    test_cas();
    chk("far side faults", 32'h0, 32'(faults));
    give_verdict();
  end
endmodule // test_dram_channel_timing_params
